//--- core/srq_top.sv
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ns
// Operation
// - operation group: condition, filters, event, enable
// - negative filter catches leaving regulation
// - standard event group: event plus enable only
// - standard event register read-only, cleared on read
// - standard enable masks events into summary
// - enable masks select error or power events
// - poll and query bytes differ only in bit 6; poll also clears the flag
// - service request drives srq and latches flag
// - poll returns flag then clears it only
// - summary is live masked OR, query clears nothing
// - reading event register clears it
// - service enable masks request, zero blocks all
// - psc set clears service enable at power-on
// - service enable values select byte bits
// - output queue is a fifo of bytes
// - message available follows non-empty output queue
// - output queue emptied by clear and power-on
// - errors push codes, query pops one
// - pushed code range sets standard event bit
// - self-test output fault pushes two codes
// - hardware fault refuses commands, queues more
// - over-long mnemonic rejected as command error
// - status byte bit layout
// - enabled operation events form bit 7
// - error queue overflow records overflow code
module srq_top #(
  parameter int OUTQ_DEPTH = 16,
  parameter int ERRQ_DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // instrument status pins
  input wire logic [15:0] oper_cond,
  input wire logic ques_summary,
  input wire logic hw_fault,
  // power-on setting and kept service enable
  input wire logic psc_setting,
  input wire logic [7:0] sre_saved,
  output logic [7:0] sre_value,
  // events from the instrument firmware
  input wire logic opc_pulse,
  input wire logic selftest_fail,
  // command gate
  input wire logic cmd_strobe,
  input wire logic [4:0] cmd_mnem_len,
  output logic cmd_accept,
  output logic cmd_reject,
  // response bytes into the output queue
  input wire logic msg_valid,
  input wire logic [7:0] msg_data,
  output logic msg_ready,
  // error codes into the error queue
  input wire logic err_valid,
  input wire logic [15:0] err_code,
  output logic err_ready,
  // service request line
  output logic srq
);
  localparam int OPW = $clog2(OUTQ_DEPTH);
  localparam int OCW = $clog2(OUTQ_DEPTH + 1);
  localparam int EPW = $clog2(ERRQ_DEPTH);
  localparam int ECW = $clog2(ERRQ_DEPTH + 1);

  if (OUTQ_DEPTH < 2 || ERRQ_DEPTH < 2) begin : g_chk
    $error("srq_top: queue depths must be at least 2");
  end

  typedef struct packed {
    logic [15:0] cond_m;
    logic [15:0] cond_s;
    logic [15:0] cond_prev;
    logic ques_m;
    logic ques_s;
    logic hw_m;
    logic hw_s;
    logic [15:0] ptr;
    logic [15:0] ntr;
    logic [15:0] oev;
    logic [15:0] oen;
    logic [7:0] esr;
    logic [7:0] ese;
    logic [7:0] sre;
    logic rqs;
    logic mss_prev;
    logic hw_seen;
    logic pend_selftest;
    logic pend_hw;
    logic pend_mnem;
    logic [OUTQ_DEPTH-1:0][7:0] oq;
    logic [OPW-1:0] oq_rd;
    logic [OCW-1:0] oq_cnt;
    logic [ERRQ_DEPTH-1:0][15:0] eq;
    logic [EPW-1:0] eq_rd;
    logic [ECW-1:0] eq_cnt;
    logic [31:0] rdata;
    logic slverr;
    logic pop_ok;
    logic accept;
    logic reject;
  } srq_state_s;

  srq_state_s q;
  srq_state_s d;

  // standard event bit for a pushed code by hundreds range
  function automatic logic [7:0] srq_err_bits(logic signed [15:0] c);
    logic [7:0] b;
    b = 8'h00;
    if (c <= srq_pkg::ERR_CMD_HI && c >= srq_pkg::ERR_CMD_LO) begin
      b[srq_pkg::SE_COMMAND_ERR] = 1'b1;
    end else if (c < srq_pkg::ERR_CMD_LO && c >= srq_pkg::ERR_EXE_LO) begin
      b[srq_pkg::SE_EXEC_ERR] = 1'b1;
    end else if (c < srq_pkg::ERR_EXE_LO && c >= srq_pkg::ERR_DEV_LO) begin
      b[srq_pkg::SE_DEVICE_ERR] = 1'b1;
    end else if (c < srq_pkg::ERR_DEV_LO && c >= srq_pkg::ERR_QRY_LO) begin
      b[srq_pkg::SE_QUERY_ERR] = 1'b1;
    end
    return b;
  endfunction

  function automatic logic [OPW-1:0] srq_oq_idx(logic [OPW-1:0] b,
                                                logic [OCW-1:0] o);
    logic [OCW:0] s;
    s = (OCW+1)'(b) + (OCW+1)'(o);
    if (s >= (OCW+1)'(OUTQ_DEPTH)) begin
      s = s - (OCW+1)'(OUTQ_DEPTH);
    end
    return s[OPW-1:0];
  endfunction

  function automatic logic [EPW-1:0] srq_eq_idx(logic [EPW-1:0] b,
                                                logic [ECW-1:0] o);
    logic [ECW:0] s;
    s = (ECW+1)'(b) + (ECW+1)'(o);
    if (s >= (ECW+1)'(ERRQ_DEPTH)) begin
      s = s - (ECW+1)'(ERRQ_DEPTH);
    end
    return s[EPW-1:0];
  endfunction

  logic [7:0] stb;
  logic mss;
  logic acc;
  logic rd_acc;
  logic wr_acc;
  logic setup;
  logic clear_status;
  logic push_err;
  logic signed [15:0] push_code;
  logic signed [15:0] stored_code;
  logic [15:0] trans;

  always_comb begin
    stb = 8'h00;
    stb[srq_pkg::STB_QUES] = q.ques_s;
    stb[srq_pkg::STB_MSG_AVAIL] = (q.oq_cnt != '0);
    stb[srq_pkg::STB_EVENT_SUM] = |(q.esr & q.ese);
    stb[srq_pkg::STB_OPER] = |(q.oev & q.oen);
    // live, unlatched; bit 6 itself never feeds back
    mss = |(stb & q.sre);
  end

  assign setup = psel & ~penable;
  assign acc = psel & penable;
  assign rd_acc = acc & ~pwrite;
  assign wr_acc = acc & pwrite;
  assign clear_status = wr_acc && paddr == srq_pkg::A_CONTROL
                        && pwdata[srq_pkg::CTRL_CLEAR_STATUS];
  assign err_ready = ~(q.pend_selftest | q.pend_hw | q.pend_mnem);
  assign msg_ready = (q.oq_cnt < OCW'(OUTQ_DEPTH));

  always_comb begin
    d = q;
    push_err = 1'b0;
    push_code = srq_pkg::ERR_NONE;
    stored_code = srq_pkg::ERR_NONE;
    trans = 16'h0000;
    d.accept = 1'b0;
    d.reject = 1'b0;
    // two-flop synchronisers for pins
    d.cond_m = oper_cond;
    d.cond_s = q.cond_m;
    d.ques_m = ques_summary;
    d.ques_s = q.ques_m;
    d.hw_m = hw_fault;
    d.hw_s = q.hw_m;
    d.cond_prev = q.cond_s;
    d.mss_prev = mss;

    // read data is captured in the setup phase
    if (setup) begin
      d.slverr = 1'b0;
      d.rdata = 32'h0000_0000;
      d.pop_ok = 1'b0;
      case (paddr)
        srq_pkg::A_OPER_COND: d.rdata = {16'h0000, q.cond_s};
        srq_pkg::A_OPER_PTR: d.rdata = {16'h0000, q.ptr};
        srq_pkg::A_OPER_NTR: d.rdata = {16'h0000, q.ntr};
        srq_pkg::A_OPER_EVENT: d.rdata = {16'h0000, q.oev};
        srq_pkg::A_OPER_ENABLE: d.rdata = {16'h0000, q.oen};
        srq_pkg::A_STD_EVENT: d.rdata = {24'h000000, q.esr};
        srq_pkg::A_STD_ENABLE: d.rdata = {24'h000000, q.ese};
        srq_pkg::A_STB_QUERY: begin
          d.rdata = {24'h000000, stb};
          d.rdata[srq_pkg::STB_SERVICE] = mss;
        end
        srq_pkg::A_STB_POLL: begin
          d.rdata = {24'h000000, stb};
          d.rdata[srq_pkg::STB_SERVICE] = q.rqs;
        end
        srq_pkg::A_SRQ_ENABLE: d.rdata = {24'h000000, q.sre};
        srq_pkg::A_OUT_QUEUE: begin
          if (q.oq_cnt != '0) begin
            d.rdata = {24'h000000, q.oq[q.oq_rd]};
            d.pop_ok = 1'b1;
          end
        end
        srq_pkg::A_ERR_QUEUE: begin
          if (q.eq_cnt != '0) begin
            d.rdata = {16'h0000, q.eq[q.eq_rd]};
            d.pop_ok = 1'b1;
          end
        end
        srq_pkg::A_CONTROL: d.rdata = 32'h0000_0000;
        default: d.slverr = 1'b1;
      endcase
    end

    // register writes and read side effects at the access edge
    if (wr_acc) begin
      case (paddr)
        srq_pkg::A_OPER_PTR: d.ptr = pwdata[15:0];
        srq_pkg::A_OPER_NTR: d.ntr = pwdata[15:0];
        srq_pkg::A_OPER_ENABLE: d.oen = pwdata[15:0];
        srq_pkg::A_STD_ENABLE: d.ese = pwdata[7:0];
        srq_pkg::A_SRQ_ENABLE: d.sre = pwdata[7:0];
        default: ;
      endcase
    end
    if (rd_acc) begin
      case (paddr)
        srq_pkg::A_OPER_EVENT: d.oev = 16'h0000;
        srq_pkg::A_STD_EVENT: d.esr = 8'h00;
        srq_pkg::A_STB_POLL: d.rqs = 1'b0;
        srq_pkg::A_OUT_QUEUE: begin
          // pop only what setup returned: a push on that edge stays queued
          if (q.pop_ok) begin
            d.oq_rd = srq_oq_idx(q.oq_rd, OCW'(1));
            d.oq_cnt = q.oq_cnt - OCW'(1);
          end
        end
        srq_pkg::A_ERR_QUEUE: begin
          if (q.pop_ok) begin
            d.eq_rd = srq_eq_idx(q.eq_rd, ECW'(1));
            d.eq_cnt = q.eq_cnt - ECW'(1);
          end
        end
        default: ;
      endcase
    end
    if (clear_status) begin
      d.oev = 16'h0000;
      d.esr = 8'h00;
      d.oq_cnt = '0;
      d.eq_cnt = '0;
    end

    // sets come after the clears so a same-cycle event is kept
    trans = (q.ptr & q.cond_s & ~q.cond_prev)
          | (q.ntr & ~q.cond_s & q.cond_prev);
    d.oev = d.oev | trans;
    if (opc_pulse || (wr_acc && paddr == srq_pkg::A_CONTROL
                      && pwdata[srq_pkg::CTRL_OP_COMPLETE])) begin
      d.esr[srq_pkg::SE_OP_COMPLETE] = 1'b1;
    end
    if (mss && !q.mss_prev) begin
      d.rqs = 1'b1;
    end

    // output queue fill from the firmware side
    if (msg_valid && msg_ready) begin
      d.oq[srq_oq_idx(d.oq_rd, d.oq_cnt)] = msg_data;
      d.oq_cnt = d.oq_cnt + OCW'(1);
    end

    // fault and command tracking
    if (selftest_fail) begin
      d.pend_selftest = 1'b1;
      d.pend_hw = 1'b1;
    end
    if (q.hw_s && !q.hw_seen) begin
      d.hw_seen = 1'b1;
      d.pend_hw = 1'b1;
    end
    if (cmd_strobe) begin
      if (q.hw_seen) begin
        d.reject = 1'b1;
        d.pend_hw = 1'b1;
      end else if (cmd_mnem_len > srq_pkg::MNEM_MAX_LEN) begin
        d.reject = 1'b1;
        d.pend_mnem = 1'b1;
      end else begin
        d.accept = 1'b1;
      end
    end

    // one error code enters the queue per cycle
    if (q.pend_selftest) begin
      push_err = 1'b1;
      push_code = srq_pkg::ERR_SELFTEST;
      d.pend_selftest = 1'b0;
    end else if (q.pend_hw) begin
      push_err = 1'b1;
      push_code = srq_pkg::ERR_HARDWARE;
      d.pend_hw = selftest_fail | (cmd_strobe & q.hw_seen);
    end else if (q.pend_mnem) begin
      push_err = 1'b1;
      push_code = srq_pkg::ERR_MNEM_LONG;
      d.pend_mnem = cmd_strobe & ~q.hw_seen
                    & (cmd_mnem_len > srq_pkg::MNEM_MAX_LEN);
    end else if (err_valid) begin
      push_err = 1'b1;
      push_code = err_code;
    end
    if (push_err) begin
      if (d.eq_cnt < ECW'(ERRQ_DEPTH - 1)) begin
        stored_code = push_code;
        d.eq[srq_eq_idx(d.eq_rd, d.eq_cnt)] = push_code;
        d.eq_cnt = d.eq_cnt + ECW'(1);
      end else if (d.eq_cnt == ECW'(ERRQ_DEPTH - 1)) begin
        // last slot is kept for the overflow marker
        stored_code = srq_pkg::ERR_OVERFLOW;
        d.eq[srq_eq_idx(d.eq_rd, d.eq_cnt)] = srq_pkg::ERR_OVERFLOW;
        d.eq_cnt = d.eq_cnt + ECW'(1);
      end
      d.esr = d.esr | srq_err_bits(stored_code);
    end

    if (!rst_n) begin
      d = '0;
      d.ptr = srq_pkg::RST_OPER_PTR;
      d.ntr = srq_pkg::RST_OPER_NTR;
      d.oen = srq_pkg::RST_OPER_ENABLE;
      d.esr = srq_pkg::RST_STD_EVENT;
      d.ese = srq_pkg::RST_STD_ENABLE;
      // otherwise the kept value comes back from storage
      d.sre = psc_setting ? 8'h00 : sre_saved;
      d.oq_cnt = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    q <= d;
  end

  // zero wait states; data was captured during setup
  assign pready = 1'b1;
  assign prdata = q.rdata;
  assign pslverr = q.slverr;
  assign sre_value = q.sre;
  assign cmd_accept = q.accept;
  assign cmd_reject = q.reject;
  assign srq = q.rqs;
endmodule // srq_top

//--- core/srq_pkg.sv
package srq_pkg;
  // register byte offsets on the apb slave
  localparam logic [7:0] A_OPER_COND = 8'h00;
  localparam logic [7:0] A_OPER_PTR = 8'h04;
  localparam logic [7:0] A_OPER_NTR = 8'h08;
  localparam logic [7:0] A_OPER_EVENT = 8'h0c;
  localparam logic [7:0] A_OPER_ENABLE = 8'h10;
  localparam logic [7:0] A_STD_EVENT = 8'h14;
  localparam logic [7:0] A_STD_ENABLE = 8'h18;
  localparam logic [7:0] A_STB_QUERY = 8'h1c;
  localparam logic [7:0] A_STB_POLL = 8'h20;
  localparam logic [7:0] A_SRQ_ENABLE = 8'h24;
  localparam logic [7:0] A_OUT_QUEUE = 8'h28;
  localparam logic [7:0] A_ERR_QUEUE = 8'h2c;
  localparam logic [7:0] A_CONTROL = 8'h30;

  // control register bits
  localparam int CTRL_CLEAR_STATUS = 0;
  localparam int CTRL_OP_COMPLETE = 1;

  // status byte bit positions
  localparam int STB_QUES = 3;
  localparam int STB_MSG_AVAIL = 4;
  localparam int STB_EVENT_SUM = 5;
  localparam int STB_SERVICE = 6;
  localparam int STB_OPER = 7;

  // standard event bit positions
  localparam int SE_OP_COMPLETE = 0;
  localparam int SE_QUERY_ERR = 2;
  localparam int SE_DEVICE_ERR = 3;
  localparam int SE_EXEC_ERR = 4;
  localparam int SE_COMMAND_ERR = 5;
  localparam int SE_POWER_ON = 7;

  // reset values
  localparam logic [15:0] RST_OPER_PTR = 16'hffff;
  localparam logic [15:0] RST_OPER_NTR = 16'h0000;
  localparam logic [15:0] RST_OPER_ENABLE = 16'h0000;
  localparam logic [7:0] RST_STD_EVENT = 8'h80;
  localparam logic [7:0] RST_STD_ENABLE = 8'h00;

  // error codes, two's complement
  localparam logic signed [15:0] ERR_NONE = 16'sh0000;
  localparam logic signed [15:0] ERR_MNEM_LONG = 16'shff90;
  localparam logic signed [15:0] ERR_HARDWARE = 16'shff10;
  localparam logic signed [15:0] ERR_SELFTEST = 16'shfeb6;
  localparam logic signed [15:0] ERR_OVERFLOW = 16'shfea2;
  // code range bounds: command, execution, device, query
  localparam logic signed [15:0] ERR_CMD_HI = 16'shff9c;
  localparam logic signed [15:0] ERR_CMD_LO = 16'shff39;
  localparam logic signed [15:0] ERR_EXE_LO = 16'shfed5;
  localparam logic signed [15:0] ERR_DEV_LO = 16'shfe71;
  localparam logic signed [15:0] ERR_QRY_LO = 16'shfe0d;

  localparam logic [4:0] MNEM_MAX_LEN = 5'h0c;
endpackage

//--- bench/srq_monitor.sv
`timescale 1ns/1ns
module srq_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // pins
  input wire logic hw_fault,
  input wire logic psc_setting,
  input wire logic [7:0] sre_saved,
  input wire logic [7:0] sre_value,
  input wire logic cmd_strobe,
  input wire logic [4:0] cmd_mnem_len,
  input wire logic cmd_accept,
  input wire logic cmd_reject,
  input wire logic msg_ready,
  input wire logic err_ready,
  input wire logic srq
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic rd_acc;
  logic wr_acc;
  assign rd_acc = psel && penable && !pwrite;
  assign wr_acc = psel && penable && pwrite;
  sre_reset_a: assert property ($rose(rst_n) |->
    sre_value == ($past(psc_setting) ? 8'h00 : $past(sre_saved)))
    else $error("bad service enable after reset");
  srq_mask_a: assert property ($rose(srq) |-> sre_value != 8'h00)
    else $error("request with empty enable");
  poll_clear_a: assert property (srq && rd_acc &&
    paddr == srq_pkg::A_STB_POLL |=> !srq) else $error("poll kept flag");
  long_reject_a: assert property (cmd_strobe && cmd_mnem_len > 5'h0c
    |=> cmd_reject && !cmd_accept) else $error("long name accepted");
  accept_len_a: assert property ($rose(cmd_accept) |->
    $past(cmd_strobe) && $past(cmd_mnem_len) <= 5'h0c)
    else $error("bad accept");
  fault_reject_a: assert property (hw_fault [*5] ##0 cmd_strobe
    |=> cmd_reject) else $error("accepted after fault");
  one_answer_a: assert property (cmd_strobe |=>
    cmd_accept != cmd_reject) else $error("no single answer");
  clear_empty_a: assert property (wr_acc &&
    paddr == srq_pkg::A_CONTROL && pwdata[0] |=> msg_ready && err_ready)
    else $error("clear left a queue full");
  cover property (srq && rd_acc && paddr == srq_pkg::A_STB_POLL);
  cover property (cmd_reject);
  cover property (wr_acc && paddr == srq_pkg::A_CONTROL);
endmodule // srq_monitor

bind srq_top srq_monitor mon (.clk_sys, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .hw_fault, .psc_setting, .sre_saved, .sre_value,
  .cmd_strobe, .cmd_mnem_len, .cmd_accept, .cmd_reject, .msg_ready,
  .err_ready, .srq);

//--- bench/srq_host.sv
`timescale 1ns/1ns
module srq_host (
  // clock
  input wire logic clk_sys,
  // register bus, controller side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} <= '0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show junk so nothing leans on stale values
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // srq_host

//--- bench/status_reporting_srq_error_queue_tb.sv
`timescale 1ns/1ns
module status_reporting_srq_error_queue_tb;
  localparam int EQ = 4;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, srq;
  logic [7:0] paddr, sre_saved, sre_value, msg_data, sre, e;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] oper_cond, err_code, code;
  logic ques_summary, hw_fault, psc_setting, opc_pulse, selftest_fail;
  logic cmd_strobe, cmd_accept, cmd_reject, msg_valid, msg_ready;
  logic err_valid, err_ready;
  logic [4:0] cmd_mnem_len;
  logic [7:0] b [3];
  logic [7:0] ese [2] = '{8'h3c, 8'h81};
  int failures = 0;
  int cmp_count = 0;
  srq_top #(.ERRQ_DEPTH(EQ)) uut (.clk_sys, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .oper_cond, .ques_summary,
    .hw_fault, .psc_setting, .sre_saved, .sre_value, .opc_pulse,
    .selftest_fail, .cmd_strobe, .cmd_mnem_len, .cmd_accept, .cmd_reject,
    .msg_valid, .msg_data, .msg_ready, .err_valid, .err_code, .err_ready,
    .srq);
  srq_host host (.clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    finish_test();
  end
  task automatic finish_test();
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    host.xfer(1'b0, a, 32'h0, r);
    chk(r, x);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, r);
  endtask
  task automatic pop(input logic [15:0] c);
    rd(srq_pkg::A_ERR_QUEUE, {16'h0, c});
  endtask
  task automatic flag(input logic v);
    #1;
    chk({31'h0, srq}, {31'h0, v});
  endtask
  // bit 6 of a query is the live masked summary of the other bits
  function automatic logic [31:0] sb(input logic [7:0] s);
    return {24'h0, s | {1'b0, |(s & sre), 6'h0}};
  endfunction
  task automatic push_err(input logic [15:0] c);
    @(posedge clk_sys);
    err_valid <= 1'b1;
    err_code <= c;
    @(posedge clk_sys);
    err_valid <= 1'b0;
  endtask
  task automatic push_msg(input logic [7:0] d);
    @(posedge clk_sys);
    msg_valid <= 1'b1;
    msg_data <= d;
    @(posedge clk_sys);
    msg_valid <= 1'b0;
  endtask
  task automatic cmd(input logic [4:0] n, input logic rej);
    @(posedge clk_sys);
    cmd_strobe <= 1'b1;
    cmd_mnem_len <= n;
    @(posedge clk_sys);
    cmd_strobe <= 1'b0;
    #1;
    chk({30'h0, cmd_accept, cmd_reject}, {30'h0, ~rej, rej});
  endtask
  task automatic do_reset(input logic p);
    psc_setting <= p;
    sre_saved <= 8'($urandom);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    sre = p ? 8'h00 : sre_saved;
    #1;
    chk({24'h0, sre_value}, {24'h0, sre});
  endtask
  initial begin
    void'($urandom(11805));
    {ques_summary, hw_fault, opc_pulse, selftest_fail, cmd_strobe} <= '0;
    {cmd_mnem_len, msg_valid, msg_data, err_valid, err_code} <= '0;
    oper_cond <= 16'h0020;
    do_reset(1'b0);
    rd(srq_pkg::A_SRQ_ENABLE, {24'h0, sre});
    rd(srq_pkg::A_STD_EVENT, 32'h80);
    wr(srq_pkg::A_STD_EVENT, 32'hff);
    rd(srq_pkg::A_STD_EVENT, 32'h0);
    // unmapped word: error response, zero data
    host.xfer(1'b0, 8'h34, 32'h0, r);
    chk(r, 32'h0);
    chk({31'h0, pslverr}, 32'h1);
    wr(srq_pkg::A_OPER_PTR, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    wr(srq_pkg::A_OPER_NTR, 32'h20);
    wr(srq_pkg::A_OPER_ENABLE, 32'h20);
    wr(srq_pkg::A_CONTROL, 32'h1);
    oper_cond <= 16'h0;
    repeat (4) @(posedge clk_sys);
    rd(srq_pkg::A_STB_QUERY, sb(8'h80));
    rd(srq_pkg::A_OPER_EVENT, 32'h20);
    rd(srq_pkg::A_OPER_EVENT, 32'h0);
    oper_cond <= 16'h0020;
    repeat (4) @(posedge clk_sys);
    rd(srq_pkg::A_STB_QUERY, sb(8'h00));
    for (int j = 0; j < 2; j++) begin
      wr(srq_pkg::A_STD_ENABLE, {24'h0, ese[j]});
      rd(srq_pkg::A_STD_ENABLE, {24'h0, ese[j]});
      for (int i = 0; i < 4; i++) begin
        wr(srq_pkg::A_CONTROL, 32'h1);
        code = 16'(-(100 * (i + 1) + int'($urandom_range(99))));
        push_err(code);
        e = {2'b0, ese[j][5 - i], 5'h0};
        rd(srq_pkg::A_STB_QUERY, sb(e));
        pop(code);
      end
    end
    wr(srq_pkg::A_CONTROL, 32'h1);
    @(posedge clk_sys);
    opc_pulse <= 1'b1;
    @(posedge clk_sys);
    opc_pulse <= 1'b0;
    rd(srq_pkg::A_STB_QUERY, sb(8'h20));
    rd(srq_pkg::A_STD_EVENT, 32'h1);
    wr(srq_pkg::A_STD_ENABLE, 32'h0);
    wr(srq_pkg::A_SRQ_ENABLE, 32'hef);
    sre = 8'hef;
    host.xfer(1'b0, srq_pkg::A_STB_POLL, 32'h0, r);
    for (int k = 0; k < 3; k++) begin
      b[k] = 8'($urandom);
      push_msg(b[k]);
    end
    flag(1'b0);
    rd(srq_pkg::A_STB_QUERY, sb(8'h10));
    wr(srq_pkg::A_SRQ_ENABLE, 32'hff);
    sre = 8'hff;
    repeat (2) @(posedge clk_sys);
    flag(1'b1);
    rd(srq_pkg::A_STB_POLL, 32'h50);
    rd(srq_pkg::A_STB_POLL, 32'h10);
    rd(srq_pkg::A_STB_QUERY, 32'h50);
    for (int k = 0; k < 3; k++) begin
      rd(srq_pkg::A_OUT_QUEUE, {24'h0, b[k]});
    end
    rd(srq_pkg::A_STB_QUERY, 32'h0);
    wr(srq_pkg::A_SRQ_ENABLE, 32'h0);
    ques_summary <= 1'b1;
    repeat (4) @(posedge clk_sys);
    flag(1'b0);
    wr(srq_pkg::A_SRQ_ENABLE, 32'h8);
    repeat (2) @(posedge clk_sys);
    flag(1'b1);
    rd(srq_pkg::A_STB_POLL, 32'h48);
    ques_summary <= 1'b0;
    push_msg(8'h5a);
    wr(srq_pkg::A_CONTROL, 32'h1);
    rd(srq_pkg::A_OUT_QUEUE, 32'h0);
    rd(srq_pkg::A_STB_QUERY, 32'h0);
    cmd(5'h0d, 1'b1);
    cmd(5'h0c, 1'b0);
    pop(srq_pkg::ERR_MNEM_LONG);
    rd(srq_pkg::A_STD_EVENT, 32'h20);
    @(posedge clk_sys);
    selftest_fail <= 1'b1;
    @(posedge clk_sys);
    selftest_fail <= 1'b0;
    pop(srq_pkg::ERR_SELFTEST);
    pop(srq_pkg::ERR_HARDWARE);
    for (int i = 0; i <= EQ; i++) begin
      push_err(16'(-101 - i));
    end
    for (int i = 0; i < EQ - 1; i++) begin
      pop(16'(-101 - i));
    end
    pop(srq_pkg::ERR_OVERFLOW);
    pop(16'h0);
    hw_fault <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmd(5'h03, 1'b1);
    pop(srq_pkg::ERR_HARDWARE);
    pop(srq_pkg::ERR_HARDWARE);
    hw_fault <= 1'b0;
    do_reset(1'b1);
    finish_test();
  end
endmodule // status_reporting_srq_error_queue_tb
